// *** logic/baud_timer.sv ***
/*
  free running baud timer giving one sampling tick per period.
  assumes a synchronous active low reset copy from the top.
*/
`timescale 1ns/100ps
`default_nettype none
module baud_timer
  import uart_rx_pkg::*;
#(
  parameter int DIV_W = 16
)(
  // clock and reset
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  // setup
  input  wire logic [DIV_W-1:0] divisor_in,
  input  wire logic             sixteen_bit_in,
  input  wire logic             slow_in,
  input  wire logic             clear_in,
  // tick
  output logic                  tick_out
);
  localparam logic [DIV_W-1:0] LOW_MASK = {DIV_W{1'b1}} >> (DIV_W / 2);
  logic [DIV_W-1:0] cnt_reg;
  logic [1:0]       presc_reg;
  logic [DIV_W-1:0] reload;
  logic             presc_done;
  assign reload     = sixteen_bit_in ? divisor_in : (divisor_in & LOW_MASK);
  assign presc_done = !slow_in || (presc_reg == PRESC_LAST);
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      cnt_reg   <= '0;
      presc_reg <= '0;
      tick_out  <= 1'b0;
    end
    else if (clear_in)
    begin
      cnt_reg   <= reload;
      presc_reg <= '0;
      tick_out  <= 1'b0;
    end
    else
    begin
      tick_out  <= 1'b0;
      presc_reg <= slow_in ? presc_reg + 2'h1 : 2'h0;
      if (presc_done)
      begin
        if (cnt_reg == '0)
        begin
          cnt_reg  <= reload;
          tick_out <= 1'b1;
        end
        else
        begin
          cnt_reg <= cnt_reg - 1'b1;
        end
      end
    end
  end
endmodule : baud_timer
`default_nettype wire

// *** logic/rx_buffer.sv ***
/*
  small first in first out store for received characters.
  assumes push is never given while full; flush empties it.
*/
`timescale 1ns/100ps
`default_nettype none
module rx_buffer
  import uart_rx_pkg::*;
#(
  parameter int W     = 10,
  parameter int DEPTH = RX_DEPTH
)(
  // clock and reset
  input  wire logic         clk_in,
  input  wire logic         rst_n_in,
  // control
  input  wire logic         flush_in,
  input  wire logic         push_in,
  input  wire logic [W-1:0] push_data_in,
  input  wire logic         pop_in,
  // state
  output logic [W-1:0]      top_out,
  output logic              empty_out,
  output logic              full_out
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
  logic [W-1:0]  mem_reg [DEPTH];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] rd_reg;
  logic [CW-1:0] cnt_reg;
  logic          do_pop;
  assign empty_out = (cnt_reg == '0);
  assign full_out  = (cnt_reg == FULL_CNT);
  assign top_out   = mem_reg[rd_reg];
  assign do_pop    = pop_in && !empty_out;
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end
    else if (flush_in)
    begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end
    else
    begin
      if (push_in)
      begin
        wr_reg <= (wr_reg == LAST_IDX) ? '0 : wr_reg + 1'b1;
      end
      if (do_pop)
      begin
        rd_reg <= (rd_reg == LAST_IDX) ? '0 : rd_reg + 1'b1;
      end
      if (push_in && !do_pop)
      begin
        cnt_reg <= cnt_reg + 1'b1;
      end
      else if (do_pop && !push_in)
      begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end
  // storage holds no reset; empty state hides stale entries
  always_ff @(posedge clk_in)
  begin
    if (push_in)
    begin
      mem_reg[wr_reg] <= push_data_in;
    end
  end
endmodule : rx_buffer
`default_nettype wire

// *** logic/uart_rx.sv ***
/*
  asynchronous serial receiver with baud timer and avalon register slave.
  assumes a remote transmitter on rx_pin_in and one avalon master.
*/
// What this block does
// - two stored characters; third sets overrun
// - overrun keeps buffer readable, blocks reception
// - overrun clears by receive or port disable
// - nine bit select shifts nine bits
// - address mode stores only ninth-bit-set characters
// - receive flag on transfer; interrupt if enabled
// - address mode characters show ninth bit one
// - baud timer eight bits, sixteen when selected
// - divisor sets period; mode bits set multiplier
// - synchronous mode ignores high speed select
// - divisor write clears baud timer at once
// - sixteen times sampling, midpoint start (fastest mode: four, start at bit end), majority
// - stop bit zero sets stored framing error
// - receive flag read-only, enabled and unread
`timescale 1ns/100ps
`default_nettype none
module uart_rx
  import uart_rx_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        rstn_in,
  // serial line
  input  wire logic        rx_pin_in,
  // avalon slave
  input  wire logic [4:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic [31:0]      avs_readdata_out,
  output logic             avs_waitrequest_out,
  // interrupt request
  output logic             rx_irq_out
);
  // ****************************************
  // declarations
  // ****************************************
  logic       rst_meta_reg;
  logic       rst_n;
  logic       rx_meta_reg;
  logic       rx_sync_reg;
  logic [7:0] ctrl_reg;
  logic       sixteen_bit_baud_select_reg;
  logic       sync_reg;
  logic       high_speed_baud_select_reg;
  logic       rie_reg;
  logic [7:0] div_low_reg;
  logic [7:0] div_high_reg;
  logic       overrun_error_flag_reg;
  logic       rflag_reg;
  rx_state_t  state_reg;
  logic [3:0] tick_cnt_reg;
  logic [3:0] bit_cnt_reg;
  logic [8:0] shift_reg;
  logic [1:0] samp_reg;
  logic       pop_pend_reg;
  logic       serial_port_enable;
  logic       continuous_receive_enable;
  logic       rx9;
  logic       address_detect_enable;
  logic       enabled;
  logic       short_bit;
  logic [3:0] last_tick;
  logic [3:0] mid_tick;
  logic [3:0] nbits;
  logic       baud_tick;
  logic       vote;
  logic       at_mid;
  logic       char_done;
  logic [8:0] char_data;
  logic       accept;
  logic       fifo_push;
  logic       fifo_pop;
  logic [9:0] fifo_top;
  logic       fifo_empty;
  logic       fifo_full;
  logic       wr_commit;
  logic       rd_take;
  logic       div_write;
  logic [31:0] read_mux;
  assign serial_port_enable  = ctrl_reg[SERIAL_PORT_ENABLE_BIT];
  assign continuous_receive_enable  = ctrl_reg[CONTINUOUS_RECEIVE_ENABLE_BIT];
  assign rx9   = ctrl_reg[RX9_BIT];
  assign address_detect_enable = ctrl_reg[ADDRESS_DETECT_ENABLE_BIT];
  assign enabled = serial_port_enable && continuous_receive_enable && !sync_reg;
  // ****************************************
  // reset and pin synchronisers
  // ****************************************
  always_ff @(posedge sys_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      rst_meta_reg <= 1'b0;
      rst_n        <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_n        <= rst_meta_reg;
    end
  end
  // line idles high
  always_ff @(posedge sys_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_meta_reg <= 1'b1;
      rx_sync_reg <= 1'b1;
    end
    else
    begin
      rx_meta_reg <= rx_pin_in;
      rx_sync_reg <= rx_meta_reg;
    end
  end
  // ****************************************
  // register slave
  // ****************************************
  // one wait cycle: accept, then complete with waitrequest low
  assign wr_commit = avs_write_in && !avs_waitrequest_out
                     && avs_byteenable_in[0];
  assign rd_take   = avs_read_in && avs_waitrequest_out;
  assign div_write = wr_commit && ((avs_address_in == DIVL_OFFSET)
                     || (avs_address_in == DIVH_OFFSET));
  always_ff @(posedge sys_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      avs_waitrequest_out <= 1'b1;
    end
    else
    begin
      avs_waitrequest_out <= !(avs_waitrequest_out
                               && (avs_read_in || avs_write_in));
    end
  end
  always_ff @(posedge sys_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_reg     <= CTRL_RESET;
      sixteen_bit_baud_select_reg    <= 1'b0;
      sync_reg     <= 1'b0;
      high_speed_baud_select_reg     <= 1'b0;
      rie_reg      <= 1'b0;
      div_low_reg  <= DIV_RESET;
      div_high_reg <= DIV_RESET;
    end
    else if (wr_commit)
    begin
      if (avs_address_in == RSC_OFFSET)
      begin
        ctrl_reg <= avs_writedata_in[7:0]
                    & ~(8'h01 << FRAMING_ERROR_FLAG_BIT)
                    & ~(8'h01 << OVERRUN_ERROR_FLAG_BIT)
                    & ~(8'h01 << NINTH_BIT);
      end
      else if (avs_address_in == BCON_OFFSET)
      begin
        sixteen_bit_baud_select_reg <= avs_writedata_in[SIXTEEN_BIT_BAUD_SELECT_BIT];
      end
      else if (avs_address_in == TSC_OFFSET)
      begin
        sync_reg <= avs_writedata_in[SYNC_BIT];
        high_speed_baud_select_reg <= avs_writedata_in[HIGH_SPEED_BAUD_SELECT_BIT];
      end
      else if (avs_address_in == DIVL_OFFSET)
      begin
        div_low_reg <= avs_writedata_in[7:0];
      end
      else if (avs_address_in == DIVH_OFFSET)
      begin
        div_high_reg <= avs_writedata_in[7:0];
      end
      else if (avs_address_in == IEN_OFFSET)
      begin
        rie_reg <= avs_writedata_in[RIE_BIT];
      end
    end
  end
  always_comb
  begin
    read_mux = 32'h0000_0000;
    if (avs_address_in == RSC_OFFSET)
    begin
      read_mux[7:0] = ctrl_reg;
      read_mux[FRAMING_ERROR_FLAG_BIT]  = fifo_top[9] && !fifo_empty;
      read_mux[OVERRUN_ERROR_FLAG_BIT]  = overrun_error_flag_reg;
      read_mux[NINTH_BIT] = fifo_top[8] && !fifo_empty;
    end
    else if (avs_address_in == DATA_OFFSET)
    begin
      read_mux[7:0] = fifo_empty ? 8'h00 : fifo_top[7:0];
    end
    else if (avs_address_in == BCON_OFFSET)
    begin
      read_mux[IDLE_BIT]  = (state_reg == ST_IDLE);
      read_mux[SIXTEEN_BIT_BAUD_SELECT_BIT] = sixteen_bit_baud_select_reg;
    end
    else if (avs_address_in == TSC_OFFSET)
    begin
      read_mux[SYNC_BIT] = sync_reg;
      read_mux[HIGH_SPEED_BAUD_SELECT_BIT] = high_speed_baud_select_reg;
    end
    else if (avs_address_in == DIVL_OFFSET)
    begin
      read_mux[7:0] = div_low_reg;
    end
    else if (avs_address_in == DIVH_OFFSET)
    begin
      read_mux[7:0] = div_high_reg;
    end
    else if (avs_address_in == IEN_OFFSET)
    begin
      read_mux[RIE_BIT]   = rie_reg;
      read_mux[RFLAG_BIT] = rflag_reg;
    end
  end
  // pop only what was returned, so a late push is never lost
  always_ff @(posedge sys_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      avs_readdata_out <= 32'h0000_0000;
      pop_pend_reg     <= 1'b0;
    end
    else if (rd_take)
    begin
      avs_readdata_out <= read_mux;
      pop_pend_reg     <= (avs_address_in == DATA_OFFSET) && !fifo_empty;
    end
    else
    begin
      pop_pend_reg <= 1'b0;
    end
  end
  assign fifo_pop = pop_pend_reg && avs_read_in && !avs_waitrequest_out;
  // ****************************************
  // baud timer
  // ****************************************
  // multiplier from mode bits
  assign short_bit = sixteen_bit_baud_select_reg && high_speed_baud_select_reg && !sync_reg;
  baud_timer #(
    .DIV_W          (16)
  ) u_baud (
    .clk_in         (sys_clk_in),
    .rst_n_in       (rst_n),
    .divisor_in     ({div_high_reg, div_low_reg}),
    .sixteen_bit_in (sixteen_bit_baud_select_reg),
    .slow_in        (!sixteen_bit_baud_select_reg && !(high_speed_baud_select_reg && !sync_reg)),
    .clear_in       (div_write),
    .tick_out       (baud_tick)
  );
  // ****************************************
  // data recovery
  // ****************************************
  // fastest mode has only four ticks per bit; vote still over three
  assign last_tick = short_bit ? LAST_SHORT : LAST_LONG;
  assign mid_tick  = short_bit ? MID_SHORT : MID_LONG;
  assign nbits     = rx9 ? BITS_NINE : BITS_EIGHT;
  assign vote   = (samp_reg[1] & samp_reg[0]) | (samp_reg[1] & rx_sync_reg)
                  | (samp_reg[0] & rx_sync_reg);
  assign at_mid = baud_tick && (tick_cnt_reg == mid_tick + 4'h1);
  always_ff @(posedge sys_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tick_cnt_reg <= 4'h0;
      samp_reg     <= 2'h3;
    end
    else if (state_reg == ST_IDLE)
    begin
      tick_cnt_reg <= 4'h0;
    end
    else if (baud_tick)
    begin
      tick_cnt_reg <= (tick_cnt_reg == last_tick) ? 4'h0
                                                  : tick_cnt_reg + 4'h1;
      samp_reg     <= {samp_reg[0], rx_sync_reg};
    end
  end
  // no new start while overrun stands
  always_ff @(posedge sys_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg   <= ST_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg   <= 9'h000;
    end
    else if (!enabled)
    begin
      state_reg <= ST_IDLE;
    end
    else
    begin
      case (state_reg)
        ST_IDLE:
        begin
          bit_cnt_reg <= 4'h0;
          if (!rx_sync_reg && !overrun_error_flag_reg)
          begin
            state_reg <= ST_START;
          end
        end
        ST_START:
        begin
          if (at_mid)
          begin
            state_reg <= vote ? ST_IDLE : ST_DATA;
          end
        end
        ST_DATA:
        begin
          if (at_mid)
          begin
            shift_reg   <= {vote, shift_reg[8:1]};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            // leave on the last data sample: in short mode the sample
            // and the bit end coincide, so waiting would eat the stop bit
            if (bit_cnt_reg == nbits - 4'h1)
            begin
              state_reg <= ST_STOP;
            end
          end
        end
        ST_STOP:
        begin
          if (at_mid)
          begin
            state_reg <= ST_IDLE;
          end
        end
        default:
        begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end
  assign char_done = enabled && (state_reg == ST_STOP) && at_mid;
  assign char_data = rx9 ? shift_reg : {1'b0, shift_reg[8:1]};
  assign accept    = char_done && !(address_detect_enable && !char_data[8]);
  assign fifo_push = accept && !fifo_full;
  // ****************************************
  // receive buffer and flags
  // ****************************************
  // stop bit zero stored as framing error
  rx_buffer #(
    .W            (10),
    .DEPTH        (RX_DEPTH)
  ) u_buf (
    .clk_in       (sys_clk_in),
    .rst_n_in     (rst_n),
    .flush_in     (!serial_port_enable),
    .push_in      (fifo_push),
    .push_data_in ({!vote, char_data}),
    .pop_in       (fifo_pop),
    .top_out      (fifo_top),
    .empty_out    (fifo_empty),
    .full_out     (fifo_full)
  );
  // cleared only by receive or port disable
  always_ff @(posedge sys_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      overrun_error_flag_reg <= 1'b0;
    end
    else if (!serial_port_enable || !continuous_receive_enable)
    begin
      overrun_error_flag_reg <= 1'b0;
    end
    else if (accept && fifo_full)
    begin
      overrun_error_flag_reg <= 1'b1;
    end
  end
  // flag follows enable and unread data
  always_ff @(posedge sys_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rflag_reg  <= 1'b0;
      rx_irq_out <= 1'b0;
    end
    else
    begin
      rflag_reg  <= enabled && !fifo_empty;
      rx_irq_out <= enabled && !fifo_empty && rie_reg;
    end
  end
  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_n);
  chk_overrun_set: assert property (
    accept && fifo_full && !fifo_pop && continuous_receive_enable && serial_port_enable
      |=> overrun_error_flag_reg && fifo_full)
    else $error("third character did not set overrun");
  chk_overrun_block: assert property (
    overrun_error_flag_reg |-> !fifo_push ##1 (state_reg != ST_START || !overrun_error_flag_reg))
    else $error("character accepted during overrun");
  chk_overrun_clear: assert property (
    $rose(overrun_error_flag_reg) |-> $past(continuous_receive_enable) && $past(serial_port_enable))
    else $error("overrun set while disabled");
  chk_ninth_shift: assert property (
    char_done |-> bit_cnt_reg == nbits)
    else $error("wrong number of data bits shifted");
  chk_address_filter: assert property (
    fifo_push && address_detect_enable |-> char_data[8] ##1 !fifo_empty)
    else $error("address mode stored a data character");
  chk_flag_irq: assert property (
    rx_irq_out |-> rflag_reg && $past(rie_reg))
    else $error("interrupt without flag and enable");
  chk_divisor_clear: assert property (
    div_write |=> !baud_tick)
    else $error("divisor write did not restart timer");
  chk_start_abort: assert property (
    state_reg == ST_START && at_mid && vote |=> state_reg == ST_IDLE
      ##1 !char_done)
    else $error("false start not aborted");
  chk_flag_level: assert property (
    enabled && !fifo_empty ##1 enabled && !fifo_empty |-> rflag_reg)
    else $error("receive flag missing with unread data");
  cov_overrun: cover property (accept && fifo_full);
  cov_addr_drop: cover property (char_done && address_detect_enable && !char_data[8]);
  cov_nine_bit: cover property (fifo_push && rx9 && char_data[8]);
  cov_framing: cover property (fifo_push && !vote);
endmodule : uart_rx
`default_nettype wire

// *** logic/uart_rx_pkg.sv ***
/*
  constants shared by the receiver top, its baud timer and its buffer.
  assumes nothing of its surroundings.
*/
`default_nettype none
package uart_rx_pkg;
  // ****************************************
  // register byte offsets
  // ****************************************
  localparam logic [4:0] RSC_OFFSET  = 5'h00;
  localparam logic [4:0] DATA_OFFSET = 5'h04;
  localparam logic [4:0] BCON_OFFSET = 5'h08;
  localparam logic [4:0] TSC_OFFSET  = 5'h0c;
  localparam logic [4:0] DIVL_OFFSET = 5'h10;
  localparam logic [4:0] DIVH_OFFSET = 5'h14;
  localparam logic [4:0] IEN_OFFSET  = 5'h18;
  // ****************************************
  // field positions
  // ****************************************
  localparam int SERIAL_PORT_ENABLE_BIT  = 7;
  localparam int RX9_BIT   = 6;
  localparam int CONTINUOUS_RECEIVE_ENABLE_BIT  = 4;
  localparam int ADDRESS_DETECT_ENABLE_BIT = 3;
  localparam int FRAMING_ERROR_FLAG_BIT  = 2;
  localparam int OVERRUN_ERROR_FLAG_BIT  = 1;
  localparam int NINTH_BIT = 0;
  localparam int IDLE_BIT  = 6;
  localparam int SIXTEEN_BIT_BAUD_SELECT_BIT = 3;
  localparam int SYNC_BIT  = 4;
  localparam int HIGH_SPEED_BAUD_SELECT_BIT  = 2;
  localparam int RIE_BIT   = 0;
  localparam int RFLAG_BIT = 1;
  // ****************************************
  // reset values and counts
  // ****************************************
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] DIV_RESET  = 8'h00;
  localparam int         RX_DEPTH   = 2;
  localparam logic [3:0] LAST_LONG  = 4'hf;
  localparam logic [3:0] MID_LONG   = 4'h8;
  localparam logic [3:0] LAST_SHORT = 4'h3;
  localparam logic [3:0] MID_SHORT  = 4'h2;
  localparam logic [1:0] PRESC_LAST = 2'h3;
  localparam logic [3:0] BITS_EIGHT = 4'h8;
  localparam logic [3:0] BITS_NINE  = 4'h9;
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_START = 4'b0010,
    ST_DATA  = 4'b0100,
    ST_STOP  = 4'b1000
  } rx_state_t;
endpackage : uart_rx_pkg
`default_nettype wire

// *** tb/tb.sv ***
/*
  self-checking bench for the serial receiver.
  assumes the receiver, its package and the transmitter model.
*/
`timescale 1ns/100ps
`default_nettype none
module tb;
  import uart_rx_pkg::*;
  // ****************************************
  // signals
  // ****************************************
  logic        sys_clk, rstn, rx_line, rd, wr, wait_req, irq;
  logic [4:0]  addr;
  logic [31:0] wdata, rdata;
  logic [3:0]  be;
  logic [31:0] exp_q[$];
  logic [7:0]  b0, b1, b2;
  int          n_fail, cmp_count, cycles;

  uart_rx uart_rx_inst (.sys_clk_in(sys_clk), .rstn_in(rstn),
    .rx_pin_in(rx_line), .avs_address_in(addr), .avs_read_in(rd),
    .avs_write_in(wr), .avs_writedata_in(wdata),
    .avs_byteenable_in(be), .avs_readdata_out(rdata),
    .avs_waitrequest_out(wait_req), .rx_irq_out(irq));
  tx_model tx_model_inst (.clk_in(sys_clk), .line_out(rx_line));

  // ****************************************
  // tasks
  // ****************************************
  always #2.5 sys_clk = ~sys_clk;
  task automatic check(string nm, logic [31:0] e, logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : check
  task automatic wr_reg(logic [4:0] a, logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= {24'h000000, d};
    wr <= 1'b1;
    do @(posedge sys_clk); while (wait_req !== 1'b0);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(logic [4:0] a, logic [7:0] e);
    exp_q.push_back({24'h000000, e});
    @(posedge sys_clk);
    addr <= a;
    rd <= 1'b1;
    do @(posedge sys_clk); while (wait_req !== 1'b0);
    rd <= 1'b0;
  endtask : rd_reg
  task automatic rx_char(logic [8:0] d, int n, logic stp, int bclk);
    tx_model_inst.send(d, n, stp, bclk);
    // storage lands at the stop sample, which in short mode is the stop bit end, within this wait
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask : rx_char
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : wrap_up
  // read results arrive at the edge waitrequest is low
  always @(posedge sys_clk)
  begin
    if (rd && wait_req === 1'b0)
      check("readdata", exp_q.pop_front(), rdata);
  end
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_fail++;
      wrap_up();
    end
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    sys_clk = 1'b0; rstn = 1'b0; rd = 1'b0; wr = 1'b0;
    addr = 5'h00; wdata = 32'h0; be = 4'h1;
    void'($urandom(26));
    b0 = 8'($urandom); b1 = 8'($urandom); b2 = 8'($urandom);
    repeat (20) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rd_reg(RSC_OFFSET, CTRL_RESET);
    rd_reg(DIVL_OFFSET, DIV_RESET);
    rd_reg(5'h1c, 8'h00);
    rd_reg(BCON_OFFSET, 8'h40);
    wr_reg(DIVL_OFFSET, 8'h03);
    wr_reg(DIVH_OFFSET, 8'h00);
    wr_reg(BCON_OFFSET, 8'h08);
    wr_reg(TSC_OFFSET, 8'h04);
    wr_reg(IEN_OFFSET, 8'h03);
    wr_reg(RSC_OFFSET, 8'h90);
    rd_reg(IEN_OFFSET, 8'h01);
    rx_char({1'b0, b0}, 8, 1'b1, 16);
    check("irq", 32'(1'b1), 32'(irq));
    rx_char({1'b0, b1}, 8, 1'b1, 16);
    rx_char({1'b0, b2}, 8, 1'b1, 16);
    rd_reg(RSC_OFFSET, 8'h92);
    rd_reg(IEN_OFFSET, 8'h03);
    rd_reg(DATA_OFFSET, b0);
    rd_reg(DATA_OFFSET, b1);
    rx_char({1'b0, b2}, 8, 1'b1, 16);
    rd_reg(DATA_OFFSET, 8'h00);
    wr_reg(RSC_OFFSET, 8'h80);
    rd_reg(RSC_OFFSET, 8'h80);
    @(negedge sys_clk);
    check("irq", 32'(1'b0), 32'(irq));
    wr_reg(RSC_OFFSET, 8'h90);
    rx_char({1'b0, b2}, 8, 1'b0, 16);
    rd_reg(RSC_OFFSET, 8'h94);
    rd_reg(DATA_OFFSET, b2);
    wr_reg(RSC_OFFSET, 8'hd0);
    rx_char({1'b1, b1}, 9, 1'b1, 16);
    rd_reg(RSC_OFFSET, 8'hd1);
    rd_reg(DATA_OFFSET, b1);
    wr_reg(RSC_OFFSET, 8'hd8);
    rx_char({1'b0, b0}, 9, 1'b1, 16);
    check("irq", 32'(1'b0), 32'(irq));
    rx_char({1'b1, b2}, 9, 1'b1, 16);
    rd_reg(RSC_OFFSET, 8'hd9);
    rd_reg(DATA_OFFSET, b2);
    wr_reg(RSC_OFFSET, 8'hd0);
    rx_char({1'b0, b0}, 9, 1'b1, 16);
    rd_reg(DATA_OFFSET, b0);
    wr_reg(RSC_OFFSET, 8'hd8);
    rx_char({1'b0, b1}, 9, 1'b1, 16);
    check("irq", 32'(1'b0), 32'(irq));
    wr_reg(BCON_OFFSET, 8'h00);
    wr_reg(TSC_OFFSET, 8'h00);
    wr_reg(DIVL_OFFSET, 8'h00);
    wr_reg(RSC_OFFSET, 8'h90);
    rx_char({1'b0, b1}, 8, 1'b1, 64);
    rd_reg(DATA_OFFSET, b1);
    rx_char({1'b0, b0}, 8, 1'b1, 64);
    wr_reg(RSC_OFFSET, 8'h10);
    rd_reg(IEN_OFFSET, 8'h01);
    rd_reg(DATA_OFFSET, 8'h00);
    repeat (4) @(posedge sys_clk);
    wrap_up();
  end
endmodule : tb
`default_nettype wire

// *** tb/tx_model.sv ***
/*
  remote serial transmitter model driving the receive line.
  assumes the bench calls send from one process only.
*/
`timescale 1ns/100ps
`default_nettype none
module tx_model (
  // clock
  input  wire logic clk_in,
  // serial line
  output logic      line_out
);
  // ****************************************
  // frame sender
  // ****************************************
  initial line_out = 1'b1;
  task automatic send(input logic [8:0] d, input int n, input logic stp,
                      input int bclk);
    logic b;
    for (int i = 0; i <= n + 1; i++)
    begin
      b = (i == 0) ? 1'b0 : ((i <= n) ? d[i-1] : stp);
      @(posedge clk_in);
      line_out <= b;
      repeat (bclk - 1) @(posedge clk_in);
    end
    // idle high: the model drives the line high between frames
    @(posedge clk_in);
    line_out <= 1'b1;
  endtask : send
endmodule : tx_model
`default_nettype wire
